// [rtl/imr_exec.sv]
// Executes indirect store, no-operation, software reset and the returns.
// Assumes the core presents one decoded instruction with instrValid and
// waits on instrReady; data memory, stack and reset unit sit outside.
`timescale 1ns/1ps
module imr_exec #(
  parameter int PtrWidth = imr_pkg::PTR_WIDTH,
  parameter int PcWidth  = imr_pkg::PC_WIDTH
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                instrValid,
  input  wire imr_pkg::imr_op_t    instrOp,
  input  wire logic                ptrSelect,
  input  wire imr_pkg::imr_mode_t  pointerUpdateMode,
  input  wire logic                relativeForm,
  input  wire logic [5:0]          offsetLiteral,
  input  wire logic [7:0]          byteLiteral,
  input  wire logic [7:0]          workingValue,
  input  wire logic [PcWidth-1:0]  topOfStack,
  input  wire logic                ptrLoadEn,
  input  wire logic                ptrLoadSelect,
  input  wire logic [PtrWidth-1:0] ptrLoadValue,
  output logic                     instrReady,
  output logic                     memWriteEn,
  output logic [PtrWidth-1:0]      memAddr,
  output logic [7:0]               memData,
  output logic [PtrWidth-1:0]      filePointer0,
  output logic [PtrWidth-1:0]      filePointer1,
  output logic                     workingLoadEn,
  output logic [7:0]               workingLoadValue,
  output logic                     pcAdvance,
  output logic                     pcLoadEn,
  output logic [PcWidth-1:0]       pcLoadValue,
  output logic                     stackPopEn,
  output logic [7:0]               interruptControlSet,
  output logic                     deviceResetReq,
  output logic                     resetInstrFlagClear
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  imr_pkg::imr_state_t  state_reg, state_next;
  imr_pkg::imr_op_t     pendOp_reg, pendOp_next;
  logic [7:0]           pendLit_reg, pendLit_next;
  logic [PtrWidth-1:0]  ptr0_reg, ptr0_next, ptr1_reg, ptr1_next;
  logic                 ready_reg, ready_next;
  logic                 memWe_reg, memWe_next;
  logic [PtrWidth-1:0]  memAddr_reg, memAddr_next;
  logic [7:0]           memData_reg, memData_next;
  logic                 wLoad_reg, wLoad_next;
  logic [7:0]           wValue_reg, wValue_next;
  logic                 pcAdv_reg, pcAdv_next;
  logic                 pcLoad_reg, pcLoad_next;
  logic [PcWidth-1:0]   pcValue_reg, pcValue_next;
  logic                 pop_reg, pop_next;
  logic [7:0]           intSet_reg, intSet_next;
  logic                 rstReq_reg, rstReq_next;
  logic                 riClr_reg, riClr_next;

  logic                 accept;
  logic [PtrWidth-1:0]  selPtr;
  logic [PtrWidth-1:0]  effAddr;
  logic [PtrWidth-1:0]  ptrAfter;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer arithmetic on the selected pointer
  assign accept = instrValid && ready_reg;
  assign selPtr = ptrSelect ? ptr1_reg : ptr0_reg;

  imr_ptr_calc #(
    .PtrWidth (PtrWidth),
    .OffWidth (imr_pkg::OFFSET_BITS)
  ) u_ptr_calc (
    .ptr      (selPtr),
    .mode     (pointerUpdateMode),
    .relative (relativeForm),
    .offset   (offsetLiteral),
    .effAddr  (effAddr),
    .ptrNext  (ptrAfter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; strobes default low so each lasts one cycle
  always_comb begin
    state_next   = state_reg;
    pendOp_next  = pendOp_reg;
    pendLit_next = pendLit_reg;
    ptr0_next    = ptr0_reg;
    ptr1_next    = ptr1_reg;
    ready_next   = ready_reg;
    memWe_next   = 1'b0;
    memAddr_next = memAddr_reg;
    memData_next = memData_reg;
    wLoad_next   = 1'b0;
    wValue_next  = wValue_reg;
    pcAdv_next   = 1'b0;
    pcLoad_next  = 1'b0;
    pcValue_next = pcValue_reg;
    pop_next     = 1'b0;
    intSet_next  = imr_pkg::BYTE_RESET;
    rstReq_next  = 1'b0;
    riClr_next   = 1'b0;
    // Core writes to a pointer; an instruction update below takes priority
    if (ptrLoadEn) begin
      if (ptrLoadSelect) ptr1_next = ptrLoadValue;
      else               ptr0_next = ptrLoadValue;
    end
    case (state_reg)
      imr_pkg::ST_IDLE: begin
        if (accept) begin
          case (instrOp)
            imr_pkg::OP_NO_OPERATION: begin
              pcAdv_next = 1'b1;
            end
            imr_pkg::OP_STORE_W_INDIRECT: begin
              // No physical indirect port: write goes to the pointed address
              memWe_next   = 1'b1;
              memAddr_next = effAddr;
              memData_next = workingValue;
              pcAdv_next   = 1'b1;
              // No status output exists, so flags cannot change here
              if (ptrSelect) ptr1_next = ptrAfter;
              else           ptr0_next = ptrAfter;
            end
            imr_pkg::OP_SOFTWARE_RESET: begin
              rstReq_next = 1'b1;
              riClr_next  = 1'b1;
            end
            imr_pkg::OP_RETURN_FROM_INTERRUPT,
            imr_pkg::OP_RETURN_WITH_LITERAL,
            imr_pkg::OP_RETURN: begin
              // Hold off the core for the second cycle
              state_next   = imr_pkg::ST_RET_SECOND;
              pendOp_next  = instrOp;
              pendLit_next = byteLiteral;
              ready_next   = 1'b0;
            end
            default: begin
              pcAdv_next = 1'b1;
            end
          endcase
        end
      end
      imr_pkg::ST_RET_SECOND: begin
        // Stack top sampled now, after any push in flight has settled
        pcLoad_next  = 1'b1;
        pcValue_next = topOfStack;
        pop_next     = 1'b1;
        if (pendOp_reg == imr_pkg::OP_RETURN_FROM_INTERRUPT) begin
          intSet_next[imr_pkg::GIE_BIT] = 1'b1;
        end
        if (pendOp_reg == imr_pkg::OP_RETURN_WITH_LITERAL) begin
          wLoad_next  = 1'b1;
          wValue_next = pendLit_reg;
        end
        state_next = imr_pkg::ST_IDLE;
        ready_next = 1'b1;
      end
      default: begin
        state_next = imr_pkg::ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; the reset unit drives resetn after a reset request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= imr_pkg::ST_IDLE;
      pendOp_reg  <= imr_pkg::OP_NO_OPERATION;
      pendLit_reg <= imr_pkg::BYTE_RESET;
      ptr0_reg    <= imr_pkg::PTR_RESET;
      ptr1_reg    <= imr_pkg::PTR_RESET;
      ready_reg   <= 1'b1;
      memWe_reg   <= 1'b0;
      memAddr_reg <= imr_pkg::PTR_RESET;
      memData_reg <= imr_pkg::BYTE_RESET;
      wLoad_reg   <= 1'b0;
      wValue_reg  <= imr_pkg::BYTE_RESET;
      pcAdv_reg   <= 1'b0;
      pcLoad_reg  <= 1'b0;
      pcValue_reg <= imr_pkg::PC_RESET;
      pop_reg     <= 1'b0;
      intSet_reg  <= imr_pkg::BYTE_RESET;
      rstReq_reg  <= 1'b0;
      riClr_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      pendOp_reg  <= pendOp_next;
      pendLit_reg <= pendLit_next;
      ptr0_reg    <= ptr0_next;
      ptr1_reg    <= ptr1_next;
      ready_reg   <= ready_next;
      memWe_reg   <= memWe_next;
      memAddr_reg <= memAddr_next;
      memData_reg <= memData_next;
      wLoad_reg   <= wLoad_next;
      wValue_reg  <= wValue_next;
      pcAdv_reg   <= pcAdv_next;
      pcLoad_reg  <= pcLoad_next;
      pcValue_reg <= pcValue_next;
      pop_reg     <= pop_next;
      intSet_reg  <= intSet_next;
      rstReq_reg  <= rstReq_next;
      riClr_reg   <= riClr_next;
    end
  end

  // Outputs straight from flip-flops
  assign instrReady          = ready_reg;
  assign memWriteEn          = memWe_reg;
  assign memAddr             = memAddr_reg;
  assign memData             = memData_reg;
  assign filePointer0        = ptr0_reg;
  assign filePointer1        = ptr1_reg;
  assign workingLoadEn       = wLoad_reg;
  assign workingLoadValue    = wValue_reg;
  assign pcAdvance           = pcAdv_reg;
  assign pcLoadEn            = pcLoad_reg;
  assign pcLoadValue         = pcValue_reg;
  assign stackPopEn          = pop_reg;
  assign interruptControlSet = intSet_reg;
  assign deviceResetReq      = rstReq_reg;
  assign resetInstrFlagClear = riClr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_store_data: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_STORE_W_INDIRECT
      |=> memWriteEn && memData == $past(workingValue))
    else $error("store did not write working value");

  a_pre_inc_addr: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_STORE_W_INDIRECT && !relativeForm
      && pointerUpdateMode == imr_pkg::MODE_PRE_INC
      |=> memAddr == PtrWidth'($past(selPtr) + 1'b1))
    else $error("preincrement address wrong");

  a_post_addr: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_STORE_W_INDIRECT && !relativeForm
      && pointerUpdateMode[1] |=> memAddr == $past(selPtr))
    else $error("post mode address not the unmodified pointer");

  a_rel_keep: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_STORE_W_INDIRECT && relativeForm && !ptrLoadEn
      && !ptrSelect |=> $stable(filePointer0))
    else $error("relative store moved the pointer");

  a_dec_after: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_STORE_W_INDIRECT && !relativeForm
      && pointerUpdateMode[0]
      |=> ($past(ptrSelect) ? filePointer1 : filePointer0) == PtrWidth'($past(selPtr) - 1'b1))
    else $error("decrement mode left pointer wrong");

  a_reset_pair: assert property (@(posedge clock) disable iff (!resetn)
    deviceResetReq |-> resetInstrFlagClear)
    else $error("software reset without cause flag clear");

  a_ret_two_cyc: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_RETURN_FROM_INTERRUPT
      |=> !instrReady ##1 pcLoadEn && stackPopEn && instrReady)
    else $error("return from interrupt not two cycles");

  a_gie_set: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_RETURN_FROM_INTERRUPT
      |=> ##1 interruptControlSet == 8'h80)
    else $error("global interrupt enable not set");

  a_return_with_literal_w: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_RETURN_WITH_LITERAL
      |=> ##1 workingLoadEn && workingLoadValue == $past(byteLiteral, 2))
    else $error("literal not loaded into working register");

  a_nop_only: assert property (@(posedge clock) disable iff (!resetn)
    accept && instrOp == imr_pkg::OP_NO_OPERATION
      |=> pcAdvance && !memWriteEn && !pcLoadEn && !workingLoadEn && instrReady)
    else $error("no-operation had a side effect");

endmodule : imr_exec

// [rtl/imr_pkg.sv]
// Constants and types shared by the indirect-store and return executer.
// Assumes one core clock and a core that sequences instruction words.
//
// Behaviour
// - Indirect store writes working register to address held in selected file pointer.
// - Update mode 00 preincrement, 01 predecrement, 10 postincrement, 11 postdecrement.
// - Pre modes write at pointer plus/minus one; post modes write at unmodified pointer.
// - Relative form writes at pointer plus signed offset -32..31; pointer unchanged.
// - Afterwards pointer is plus one for increments, minus one for decrements.
// - File pointer is 16 bits and wraps at both ends.
// - Indirect store and its pointer update alter no status flag.
// - Software reset instruction requests a full device reset, like hardware reset.
// - Software reset clears the active-low reset-instruction cause flag.
// - Return from interrupt pops stack, loads PC from top, takes two cycles.
// - Return from interrupt sets global interrupt enable, bit 7 of interrupt control.
// - Return with literal loads W with literal, PC from stack, two cycles, no flags.
// - Subroutine return pops stack, loads PC with return address, two cycles.
package imr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and field positions
  localparam int PTR_WIDTH   = 16;
  localparam int PC_WIDTH    = 15;
  localparam int OFFSET_BITS = 6;
  localparam int GIE_BIT     = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [14:0] PC_RESET  = 15'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction selector as decoded by the core
  typedef enum logic [2:0] {
    OP_NO_OPERATION          = 3'b000,
    OP_STORE_W_INDIRECT      = 3'b001,
    OP_SOFTWARE_RESET        = 3'b010,
    OP_RETURN_FROM_INTERRUPT = 3'b011,
    OP_RETURN_WITH_LITERAL   = 3'b100,
    OP_RETURN                = 3'b101
  } imr_op_t;

  // Pointer update mode field encoding
  typedef enum logic [1:0] {
    MODE_PRE_INC  = 2'b00,
    MODE_PRE_DEC  = 2'b01,
    MODE_POST_INC = 2'b10,
    MODE_POST_DEC = 2'b11
  } imr_mode_t;

  // Executer states: second cycle of the two-cycle returns
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RET_SECOND = 2'b01
  } imr_state_t;

endpackage : imr_pkg

// [rtl/imr_ptr_calc.sv]
// Effective address and updated value for one file pointer.
// Assumes the caller registers the results; purely combinational.
`timescale 1ns/1ps
module imr_ptr_calc #(
  parameter int PtrWidth = 16,
  parameter int OffWidth = 6
) (
  input  wire logic [PtrWidth-1:0] ptr,
  input  wire imr_pkg::imr_mode_t  mode,
  input  wire logic                relative,
  input  wire logic [OffWidth-1:0] offset,
  output logic      [PtrWidth-1:0] effAddr,
  output logic      [PtrWidth-1:0] ptrNext
);

  logic [PtrWidth-1:0] offsetExt;
  logic [PtrWidth-1:0] ptrInc;
  logic [PtrWidth-1:0] ptrDec;

  // Sign-extend offset; 16-bit sums wrap naturally at both ends
  always_comb begin
    offsetExt = {{(PtrWidth-OffWidth){offset[OffWidth-1]}}, offset};
    ptrInc    = ptr + {{(PtrWidth-1){1'b0}}, 1'b1};
    ptrDec    = ptr - {{(PtrWidth-1){1'b0}}, 1'b1};
  end

  // Address chosen per mode, pointer moved per direction
  always_comb begin
    if (relative) begin
      effAddr = ptr + offsetExt;
      ptrNext = ptr;
    end else begin
      case (mode)
        imr_pkg::MODE_PRE_INC:  effAddr = ptrInc;
        imr_pkg::MODE_PRE_DEC:  effAddr = ptrDec;
        imr_pkg::MODE_POST_INC: effAddr = ptr;
        imr_pkg::MODE_POST_DEC: effAddr = ptr;
        default:                effAddr = ptr;
      endcase
      ptrNext = mode[0] ? ptrDec : ptrInc;
    end
  end

endmodule : imr_ptr_calc

// [test/tb_imr_exec.sv]
// Self-checking bench for the indirect-store and return executer.
// Assumes imr_pkg and imr_exec are compiled first; the bench plays the core.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin checks++; if ((got) !== (exp)) begin errTotal++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end

module tb_imr_exec;
  logic                clock;
  logic                resetn;
  logic                instrValid;
  imr_pkg::imr_op_t    instrOp;
  logic                ptrSelect;
  imr_pkg::imr_mode_t  pointerUpdateMode;
  logic                relativeForm;
  logic [5:0]          offsetLiteral;
  logic [7:0]          byteLiteral;
  logic [7:0]          workingValue;
  logic [14:0]         topOfStack;
  logic                ptrLoadEn;
  logic                ptrLoadSelect;
  logic [15:0]         ptrLoadValue;
  logic                instrReady;
  logic                memWriteEn;
  logic [15:0]         memAddr;
  logic [7:0]          memData;
  logic [15:0]         filePointer0;
  logic [15:0]         filePointer1;
  logic                workingLoadEn;
  logic [7:0]          workingLoadValue;
  logic                pcAdvance;
  logic                pcLoadEn;
  logic [14:0]         pcLoadValue;
  logic                stackPopEn;
  logic [7:0]          interruptControlSet;
  logic                deviceResetReq;
  logic                resetInstrFlagClear;
  int                  errTotal;
  int                  checks;

  imr_exec uut (
    .clock(clock), .resetn(resetn), .instrValid(instrValid), .instrOp(instrOp),
    .ptrSelect(ptrSelect), .pointerUpdateMode(pointerUpdateMode),
    .relativeForm(relativeForm), .offsetLiteral(offsetLiteral), .byteLiteral(byteLiteral),
    .workingValue(workingValue), .topOfStack(topOfStack), .ptrLoadEn(ptrLoadEn),
    .ptrLoadSelect(ptrLoadSelect), .ptrLoadValue(ptrLoadValue), .instrReady(instrReady),
    .memWriteEn(memWriteEn), .memAddr(memAddr), .memData(memData),
    .filePointer0(filePointer0), .filePointer1(filePointer1),
    .workingLoadEn(workingLoadEn), .workingLoadValue(workingLoadValue),
    .pcAdvance(pcAdvance), .pcLoadEn(pcLoadEn), .pcLoadValue(pcLoadValue),
    .stackPopEn(stackPopEn), .interruptControlSet(interruptControlSet),
    .deviceResetReq(deviceResetReq), .resetInstrFlagClear(resetInstrFlagClear)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz core clock
  always #5 clock = ~clock;

  // Verdict, shared by the main sequence and the watchdog
  task automatic finalReport;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finalReport

  ////////////////////////////////////////////////////////////////////////////
  // Core-side drivers; every change lands 1 ns after an edge
  task automatic loadPtr(input logic sel, input logic [15:0] val);
    @(posedge clock); #1;
    ptrLoadEn = 1'b1;
    ptrLoadSelect = sel;
    ptrLoadValue = val;
    @(posedge clock); #1;
    ptrLoadEn = 1'b0;
  endtask : loadPtr

  // Offers one instruction; returns in the cycle after the accept edge
  task automatic issue(input imr_pkg::imr_op_t op);
    @(posedge clock); #1;
    instrValid = 1'b1;
    instrOp = op;
    @(posedge clock); #1;
    instrValid = 1'b0;
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////
  // One store; the other pointer is parked at a marker to catch cross-talk
  task automatic checkStore(input logic sel, input logic [15:0] p,
                            input imr_pkg::imr_mode_t md, input logic rel,
                            input logic [5:0] off);
    logic [15:0] ea;
    logic [15:0] pn;
    ea = p;
    pn = p;
    if (rel) ea = p + {{10{off[5]}}, off};
    else if (md == imr_pkg::MODE_PRE_INC) begin ea = p + 16'h0001; pn = ea; end
    else if (md == imr_pkg::MODE_PRE_DEC) begin ea = p - 16'h0001; pn = ea; end
    else if (md == imr_pkg::MODE_POST_INC) pn = p + 16'h0001;
    else pn = p - 16'h0001;
    loadPtr(sel, p);
    loadPtr(!sel, 16'h5a5a);
    ptrSelect = sel;
    pointerUpdateMode = md;
    relativeForm = rel;
    offsetLiteral = off;
    workingValue = p[7:0] ^ 8'h3c;
    issue(imr_pkg::OP_STORE_W_INDIRECT);
    `CHK("memWriteEn", 1'b1, memWriteEn)
    `CHK("memData", p[7:0] ^ 8'h3c, memData)
    `CHK("memAddr", ea, memAddr)
    `CHK("selected pointer", pn, sel ? filePointer1 : filePointer0)
    `CHK("other pointer", 16'h5a5a, sel ? filePointer0 : filePointer1)
    `CHK("pcAdvance", 1'b1, pcAdvance)
    @(posedge clock); #1;
    `CHK("memWriteEn drop", 1'b0, memWriteEn)
  endtask : checkStore

  // Two stores on consecutive edges; the second sees the first's update
  task automatic backToBack;
    loadPtr(1'b0, 16'h1234);
    ptrSelect = 1'b0;
    pointerUpdateMode = imr_pkg::MODE_POST_INC;
    relativeForm = 1'b0;
    workingValue = 8'ha5;
    @(posedge clock); #1;
    instrValid = 1'b1;
    instrOp = imr_pkg::OP_STORE_W_INDIRECT;
    @(posedge clock); #1;
    workingValue = 8'h5a;
    `CHK("first addr", 16'h1234, memAddr)
    @(posedge clock); #1;
    instrValid = 1'b0;
    `CHK("second write", 1'b1, memWriteEn)
    `CHK("second addr", 16'h1235, memAddr)
    `CHK("second data", 8'h5a, memData)
    `CHK("pointer after two", 16'h1236, filePointer0)
  endtask : backToBack

  // No-operation only advances the program counter
  task automatic checkNop;
    issue(imr_pkg::OP_NO_OPERATION);
    `CHK("nop pcAdvance", 1'b1, pcAdvance)
    `CHK("nop write", 1'b0, memWriteEn)
    `CHK("nop pcLoad", 1'b0, pcLoadEn | workingLoadEn | stackPopEn)
    `CHK("nop pointer", 16'h1236, filePointer0)
    `CHK("nop ready", 1'b1, instrReady)
  endtask : checkNop

  ////////////////////////////////////////////////////////////////////////////
  // Two-cycle return; valid stays up so a store offered in the busy cycle is dropped
  task automatic checkReturn(input imr_pkg::imr_op_t op, input logic [14:0] top_of_stack,
                             input logic [7:0] lit);
    byteLiteral = lit;
    @(posedge clock); #1;
    instrValid = 1'b1;
    instrOp = op;
    @(posedge clock); #1;
    `CHK("busy ready", 1'b0, instrReady)
    `CHK("early pcLoad", 1'b0, pcLoadEn)
    topOfStack = top_of_stack;
    byteLiteral = ~lit;
    instrOp = imr_pkg::OP_STORE_W_INDIRECT;
    @(posedge clock); #1;
    instrValid = 1'b0;
    topOfStack = ~top_of_stack;
    `CHK("pcLoadEn", 1'b1, pcLoadEn)
    `CHK("stackPopEn", 1'b1, stackPopEn)
    `CHK("pcLoadValue", top_of_stack, pcLoadValue)
    `CHK("gie set", (op == imr_pkg::OP_RETURN_FROM_INTERRUPT) ? 8'h80 : 8'h00,
         interruptControlSet)
    `CHK("wLoad", op == imr_pkg::OP_RETURN_WITH_LITERAL, workingLoadEn)
    if (op == imr_pkg::OP_RETURN_WITH_LITERAL) `CHK("wValue", lit, workingLoadValue)
    `CHK("refused store", 1'b0, memWriteEn)
    `CHK("ready again", 1'b1, instrReady)
    @(posedge clock); #1;
    `CHK("pulses drop", 1'b0, pcLoadEn | stackPopEn | workingLoadEn)
    `CHK("gie drop", 8'h00, interruptControlSet)
  endtask : checkReturn

  // Software reset asks for a device reset; the bench then plays the reset unit
  task automatic checkSoftReset;
    issue(imr_pkg::OP_SOFTWARE_RESET);
    `CHK("resetReq", 1'b1, deviceResetReq)
    `CHK("flagClear", 1'b1, resetInstrFlagClear)
    `CHK("reset no advance", 1'b0, pcAdvance | memWriteEn)
    @(posedge clock); #1;
    `CHK("resetReq drop", 1'b0, deviceResetReq | resetInstrFlagClear)
    resetn = 1'b0;
    #1;
    `CHK("pointer cleared", 16'h0000, filePointer0)
    `CHK("pointer1 cleared", 16'h0000, filePointer1)
    @(posedge clock); #1;
    resetn = 1'b1;
  endtask : checkSoftReset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    instrValid = 1'b0;
    instrOp = imr_pkg::OP_NO_OPERATION;
    ptrSelect = 1'b0;
    pointerUpdateMode = imr_pkg::MODE_PRE_INC;
    relativeForm = 1'b0;
    offsetLiteral = 6'h00;
    byteLiteral = 8'h00;
    workingValue = 8'h00;
    topOfStack = 15'h0000;
    ptrLoadEn = 1'b0;
    ptrLoadSelect = 1'b0;
    ptrLoadValue = 16'h0000;
    errTotal = 0;
    checks = 0;
    repeat (16) @(posedge clock);
    #1;
    resetn = 1'b1;
    `CHK("reset ready", 1'b1, instrReady)
    `CHK("reset pointers", 32'h0000_0000, {filePointer0, filePointer1})
    // Wrap in every mode, increments at the top end and decrements at the bottom, then both offset extremes
    checkStore(1'b0, 16'hffff, imr_pkg::MODE_PRE_INC, 1'b0, 6'h00);
    checkStore(1'b1, 16'h0000, imr_pkg::MODE_PRE_DEC, 1'b0, 6'h00);
    checkStore(1'b0, 16'hffff, imr_pkg::MODE_POST_INC, 1'b0, 6'h00);
    checkStore(1'b1, 16'h0000, imr_pkg::MODE_POST_DEC, 1'b0, 6'h00);
    checkStore(1'b1, 16'h0010, imr_pkg::MODE_PRE_INC, 1'b1, 6'h20);
    checkStore(1'b0, 16'hfff0, imr_pkg::MODE_POST_DEC, 1'b1, 6'h1f);
    backToBack();
    checkNop();
    checkReturn(imr_pkg::OP_RETURN_FROM_INTERRUPT, 15'h7fff, 8'h00);
    checkReturn(imr_pkg::OP_RETURN_WITH_LITERAL, 15'h0001, 8'hff);
    checkReturn(imr_pkg::OP_RETURN, 15'h2aaa, 8'h5c);
    checkSoftReset();
    finalReport();
  end

  // Watchdog: the sequence needs well under 200 cycles
  initial begin
    #20000;
    errTotal++;
    finalReport();
  end
endmodule : tb_imr_exec
